/* File: seeio_access.sv */
// apb register bank for serial eeprom byte access and i/o expander pin access
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "seeio_regs.svh"
module seeio_access (
  input  wire logic                    pclk,       // bus clock, 25 MHz
  input  wire logic                    presetn,    // async reset, active low
  input  wire logic                    psel,       // apb select
  input  wire logic                    penable,    // apb access phase
  input  wire logic                    pwrite,     // apb direction
  input  wire logic [11:0]             paddr,      // apb byte address
  input  wire logic [31:0]             pwdata,     // apb write data
  input  wire logic [3:0]              pstrb,      // apb byte lanes
  output logic      [31:0]             prdata,     // apb read data
  output logic                         pready,     // apb ready
  output logic                         pslverr,    // unmapped address
  output logic                         eep_valid,  // eeprom request outstanding
  output seeio_pkg::seeio_eep_req_t    eep_req,    // eeprom request payload
  input  wire logic                    eep_ack,    // eeprom access finished
  input  wire logic [7:0]              eep_rdata,  // byte fetched on read
  output logic                         ioe_valid,  // expander request outstanding
  output seeio_pkg::seeio_ioe_req_t    ioe_req,    // expander request payload
  input  wire logic                    ioe_ack,    // expander transaction finished
  input  wire logic [15:0]             ioe_rdata,  // pin values read back
  input  wire logic [63:0]             ioe_dir,    // per pin, one marks an input
  input  wire logic [63:0]             ioe_core,   // output values from core logic
  output logic      [63:0]             ioe_drive,  // output values supplied
  output logic                         irq         // level interrupt
);
  import seeio_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic setup;
  logic wr_acc;
  logic eep_wr;
  logic ioe_wr;
  logic icl_wr;
  logic ien_wr;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready;
  assign eep_wr = wr_acc & (paddr == `SEEIO_EEP_OFS);
  assign ioe_wr = wr_acc & (paddr == `SEEIO_IOE_OFS);
  assign icl_wr = wr_acc & (paddr == `SEEIO_ICL_OFS);
  assign ien_wr = wr_acc & (paddr == `SEEIO_IEN_OFS);

  // {valid, index} of a select code
  function automatic logic [2:0] slot_of(input logic [3:0] s);
    case (s)
      `SEEIO_SEL_E0: slot_of = `SEEIO_SLOT_E0;
      `SEEIO_SEL_E1: slot_of = `SEEIO_SLOT_E1;
      `SEEIO_SEL_E2: slot_of = `SEEIO_SLOT_E2;
      `SEEIO_SEL_E4: slot_of = `SEEIO_SLOT_E4;
      default:       slot_of = `SEEIO_ZERO_SLOT;
    endcase
  endfunction : slot_of

  //////////////////////////////////////////////////////////////////////////////
  // eeprom byte access

  logic [15:0] eaddr_r;
  logic [7:0]  edata_r;
  logic        erd_r;
  logic        edone;
  logic        efin;
  logic        eacc;
  logic        erd_w;
  logic [15:0] eaddr_w;
  logic        estart;

  // a write while busy can only clear done, the rest is dropped so the payload in flight stays put
  assign eacc    = eep_wr & ~eep_valid;
  assign erd_w   = pstrb[`SEEIO_LANE_TOP] ? pwdata[`SEEIO_EEP_RD] : erd_r;
  assign eaddr_w = (|pstrb[`SEEIO_LANE_LO]) ? pwdata[`SEEIO_ADDR_RNG] : eaddr_r;
  assign estart  = eacc & pstrb[`SEEIO_LANE_DATA];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eaddr_r <= `SEEIO_RST_W16;
    end else if (eacc) begin
      eaddr_r <= eaddr_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erd_r <= 1'b0;
    end else if (eacc) begin
      erd_r <= erd_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edata_r <= `SEEIO_RST_B8;
    end else if (efin && eep_req.rd) begin
      edata_r <= eep_rdata;
    end else if (estart && !erd_w) begin
      edata_r <= pwdata[`SEEIO_DATA_RNG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eep_req <= '0;
    end else if (estart) begin
      eep_req.rd    <= erd_w;
      eep_req.addr  <= eaddr_w;
      eep_req.wdata <= pwdata[`SEEIO_DATA_RNG];
    end
  end

  seeio_xfer u_eep (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (estart),
    .ack     (eep_ack),
    .clr     (eep_wr & pstrb[`SEEIO_LANE_TOP] & pwdata[`SEEIO_EEP_DONE]),
    .busy    (eep_valid),
    .done    (edone),
    .fin     (efin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // i/o expander access

  logic        tm_r;
  logic [3:0]  sel_r;
  logic [3:0]  sel_w;
  logic [2:0]  slot_w;
  logic [2:0]  slot_r;
  logic        twr;
  logic        rfr;
  logic        istart;
  logic        idone;
  logic        ifin;
  logic [15:0] tval_r [4];
  logic [15:0] pin_r  [4];
  logic [15:0] drv_r  [4];
  logic [15:0] view   [4];

  assign sel_w  = pstrb[`SEEIO_LANE_TOP] ? pwdata[`SEEIO_SEL_RNG] : sel_r;
  assign slot_w = slot_of(sel_w);
  assign slot_r = slot_of(sel_r);
  assign twr    = ioe_wr & tm_r & (|pstrb[`SEEIO_LANE_LO]) & slot_w[2];
  assign rfr    = ioe_wr & pstrb[`SEEIO_LANE_TOP] & pwdata[`SEEIO_IOE_RELOAD] & slot_w[2];
  assign istart = (rfr | twr) & ~ioe_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_r  <= 1'b0;
      sel_r <= `SEEIO_RST_SEL;
    end else if (ioe_wr && pstrb[`SEEIO_LANE_TOP]) begin
      tm_r  <= pwdata[`SEEIO_IOE_TM];
      sel_r <= pwdata[`SEEIO_SEL_RNG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ioe_req <= '0;
    end else if (istart) begin
      ioe_req.refresh <= rfr;
      ioe_req.slot    <= slot_w[1:0];
    end
  end

  seeio_xfer u_ioe (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (istart),
    .ack     (ioe_ack),
    .clr     (ioe_wr & pstrb[`SEEIO_LANE_TOP] & pwdata[`SEEIO_IOE_DONE]),
    .busy    (ioe_valid),
    .done    (idone),
    .fin     (ifin)
  );

  for (genvar i = 0; i < 4; i++) begin : g_exp
    logic [15:0] dir_i;
    assign dir_i = ioe_dir[i*16 +: 16];

    // input bits keep their old test value, they can never be driven
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tval_r[i] <= `SEEIO_RST_W16;
      end else if (twr && slot_w[1:0] == 2'(i)) begin
        tval_r[i] <= (pwdata[`SEEIO_PIN_RNG] & ~dir_i) | (tval_r[i] & dir_i);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_r[i] <= `SEEIO_RST_W16;
      end else if (ifin && ioe_req.slot == 2'(i)) begin
        pin_r[i] <= ioe_rdata & dir_i;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        drv_r[i] <= `SEEIO_RST_W16;
      end else begin
        drv_r[i] <= (tm_r ? tval_r[i] : ioe_core[i*16 +: 16]) & ~dir_i;
      end
    end

    assign view[i] = (pin_r[i] & dir_i) | drv_r[i];
    assign ioe_drive[i*16 +: 16] = drv_r[i];
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable

  logic [1:0] ist_r;
  logic [1:0] ien_r;
  logic [1:0] ist_ev;
  logic [1:0] ist_clr;

  assign ist_ev[`SEEIO_IRQ_EEP] = efin;
  assign ist_ev[`SEEIO_IRQ_IOE] = ifin;
  assign ist_clr = icl_wr ? pwdata[`SEEIO_IRQ_RNG] : `SEEIO_RST_IRQ;

  // new events win over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= `SEEIO_RST_IRQ;
    end else begin
      ist_r <= (ist_r & ~ist_clr) | ist_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= `SEEIO_RST_IRQ;
    end else if (ien_wr) begin
      ien_r <= pwdata[`SEEIO_IRQ_RNG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_r & ien_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path: data is captured in the setup cycle, answer in the next

  logic [31:0] rd_nxt;
  logic        hit_nxt;

  always_comb begin
    rd_nxt  = `SEEIO_RST_W32;
    hit_nxt = 1'b1;
    case (paddr)
      `SEEIO_EEP_OFS: begin
        rd_nxt[`SEEIO_ADDR_RNG] = eaddr_r;
        rd_nxt[`SEEIO_DATA_RNG] = edata_r;
        rd_nxt[`SEEIO_EEP_BUSY] = eep_valid;
        rd_nxt[`SEEIO_EEP_DONE] = edone;
        rd_nxt[`SEEIO_EEP_RD]   = erd_r;
      end
      `SEEIO_IOE_OFS: begin
        // refresh bit is left at zero
        rd_nxt[`SEEIO_PIN_RNG]  = slot_r[2] ? view[slot_r[1:0]] : `SEEIO_RST_W16;
        rd_nxt[`SEEIO_IOE_TM]   = tm_r;
        rd_nxt[`SEEIO_SEL_RNG]  = sel_r;
        rd_nxt[`SEEIO_IOE_DONE] = idone;
      end
      `SEEIO_IST_OFS: rd_nxt[`SEEIO_IRQ_RNG] = ist_r;
      `SEEIO_ICL_OFS: rd_nxt = `SEEIO_RST_W32;
      `SEEIO_IEN_OFS: rd_nxt[`SEEIO_IRQ_RNG] = ien_r;
      default:        hit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SEEIO_RST_W32;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_nxt;
      if (setup) begin
        prdata <= rd_nxt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  eep_start_a: assert property (estart |=> eep_valid && eep_req.addr == eaddr_r)
    else $error("eeprom access not launched at stored address");
  eep_wdata_a: assert property (estart && !erd_w |=> eep_req.wdata == edata_r && !eep_req.rd)
    else $error("eeprom write byte not forwarded");
  eep_rdata_a: assert property (efin && eep_req.rd |=> edata_r == $past(eep_rdata) && edone)
    else $error("eeprom read byte not captured");
  eep_busy_a: assert property (setup && paddr == `SEEIO_EEP_OFS |=> prdata[`SEEIO_EEP_BUSY] == $past(eep_valid))
    else $error("busy bit does not match access state");
  eep_done_a: assert property (edone && !eep_wr |=> edone)
    else $error("eeprom done cleared without a write");
  eep_kind_a: assert property (estart |=> eep_req.rd == $past(erd_w) && erd_r == eep_req.rd)
    else $error("eeprom access kind wrong");
  pin_lock_a: assert property (ioe_wr && !tm_r |=> $stable(tval_r[0]) && $stable(tval_r[3]))
    else $error("pin write taken outside test mode");
  test_drive_a: assert property (tm_r ##1 tm_r |-> drv_r[0] == ($past(tval_r[0]) & ~$past(ioe_dir[15:0])))
    else $error("test values not driven");
  pin_input_a: assert property (twr && slot_w[1:0] == 2'h1 |=>
    ((tval_r[1] ^ $past(tval_r[1])) & $past(ioe_dir[31:16])) == `SEEIO_RST_W16)
    else $error("input pin written");
  refresh_go_a: assert property (rfr && !ioe_valid |=> ioe_valid && ioe_req.refresh &&
    ioe_req.slot == $past(slot_w[1:0]))
    else $error("refresh not issued");
  reload_zero_a: assert property (setup && paddr == `SEEIO_IOE_OFS |=> !prdata[`SEEIO_IOE_RELOAD] ##0 pready)
    else $error("refresh bit read back as one");
  sel_rsvd_a: assert property (setup && paddr == `SEEIO_IOE_OFS && !slot_r[2] |=> prdata[15:0] == 16'h0000)
    else $error("reserved select shows pins");
  ioe_done_a: assert property (ifin |=> idone && ist_r[`SEEIO_IRQ_IOE])
    else $error("expander done not set");

  eep_read_c: cover property (estart && erd_w ##[1:50] efin);
  refresh_c: cover property (rfr && !ioe_valid ##[1:50] ifin);
  irq_c: cover property (!irq ##1 irq);

endmodule : seeio_access

/* File: seeio_far.sv */
// behavioural serial eeprom and i/o expanders standing behind the smbus engine
`timescale 1ns/1ps
module seeio_far #(
  parameter int DLY = 6 // one less than the cycles from request to completion
) (
  input  wire logic                      pclk,      // bus clock
  input  wire logic                      presetn,   // async reset, active low
  input  wire logic                      eep_valid, // eeprom request
  input  wire seeio_pkg::seeio_eep_req_t eep_req,   // eeprom payload
  output logic                           eep_ack,   // eeprom done pulse
  output logic      [7:0]                eep_rdata, // fetched byte
  input  wire logic                      ioe_valid, // expander request
  input  wire seeio_pkg::seeio_ioe_req_t ioe_req,   // expander payload
  output logic                           ioe_ack,   // expander done pulse
  output logic      [15:0]               ioe_rdata  // pins read back
);
  import seeio_pkg::*;
  logic [7:0] mem [256];
  int         ecnt;
  int         icnt;
  ////////////////////////////////////////////////////////////////////////////////
  // released data lines toggle so a sample one cycle late sees the inverted value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt      <= 0;
      eep_ack   <= 1'b0;
      eep_rdata <= 8'h00;
    end else begin
      eep_ack   <= 1'b0;
      eep_rdata <= ~eep_rdata;
      if (eep_valid && !eep_ack) begin
        ecnt <= ecnt + 1;
        if (ecnt == DLY) begin
          ecnt    <= 0;
          eep_ack <= 1'b1;
          if (eep_req.rd) begin
            eep_rdata <= mem[eep_req.addr[7:0]];
          end else begin
            mem[eep_req.addr[7:0]] <= eep_req.wdata;
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt      <= 0;
      ioe_ack   <= 1'b0;
      ioe_rdata <= 16'h0000;
    end else begin
      ioe_ack   <= 1'b0;
      ioe_rdata <= ~ioe_rdata;
      if (ioe_valid && !ioe_ack) begin
        icnt <= icnt + 1;
        if (icnt == DLY) begin
          icnt      <= 0;
          ioe_ack   <= 1'b1;
          ioe_rdata <= 16'ha5c0 | {14'h0000, ioe_req.slot};
        end
      end
    end
  end
endmodule : seeio_far

/* File: seeio_pkg.sv */
// shared types of the eeprom / expander access block
package seeio_pkg;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } seeio_eep_req_t;

  typedef struct packed {
    logic       refresh;
    logic [1:0] slot;
  } seeio_ioe_req_t;

  typedef enum logic {
    st_idle,
    st_busy
  } seeio_xst_t;

endpackage : seeio_pkg

/* File: seeio_regs.svh */
// register offsets, field positions and reset values of the eeprom / expander access block
`ifndef SEEIO_REGS_SVH
`define SEEIO_REGS_SVH

`define SEEIO_EEP_OFS    12'h34c
`define SEEIO_IOE_OFS    12'h350
`define SEEIO_IST_OFS    12'h360
`define SEEIO_ICL_OFS    12'h364
`define SEEIO_IEN_OFS    12'h368

`define SEEIO_ADDR_RNG   15:0
`define SEEIO_DATA_RNG   23:16
`define SEEIO_EEP_BUSY   24
`define SEEIO_EEP_DONE   25
`define SEEIO_EEP_RD     26

`define SEEIO_PIN_RNG    15:0
`define SEEIO_IOE_RELOAD 24
`define SEEIO_IOE_TM     25
`define SEEIO_SEL_RNG    29:26
`define SEEIO_IOE_DONE   31

`define SEEIO_SEL_E0     4'h0
`define SEEIO_SEL_E1     4'h1
`define SEEIO_SEL_E2     4'h2
`define SEEIO_SEL_E4     4'h4

`define SEEIO_LANE_LO    1:0
`define SEEIO_LANE_DATA  2
`define SEEIO_LANE_TOP   3

`define SEEIO_IRQ_RNG    1:0
`define SEEIO_IRQ_EEP    0
`define SEEIO_IRQ_IOE    1

`define SEEIO_RST_B8     8'h00
`define SEEIO_RST_W16    16'h0000
`define SEEIO_RST_SEL    4'h0
`define SEEIO_RST_IRQ    2'h0
`define SEEIO_RST_W32    32'h0000_0000
`define SEEIO_ZERO_SLOT  3'h0
`define SEEIO_SLOT_E0    3'h4
`define SEEIO_SLOT_E1    3'h5
`define SEEIO_SLOT_E2    3'h6
`define SEEIO_SLOT_E4    3'h7

`endif

/* File: seeio_xfer.sv */
// one outstanding request toward the smbus engine, with sticky completion flag
`timescale 1ns/1ps
module seeio_xfer (
  input  wire logic pclk,    // bus clock
  input  wire logic presetn, // async reset, active low
  input  wire logic start,   // launch request
  input  wire logic ack,     // engine finished
  input  wire logic clr,     // write one to clear done
  output logic      busy,    // request outstanding
  output logic      done,    // sticky completion
  output logic      fin      // completion pulse
);
  import seeio_pkg::*;

  seeio_xst_t st_r;

  assign busy = (st_r == st_busy);
  assign fin  = busy & ack;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= st_idle;
    end else begin
      case (st_r)
        st_idle: begin
          if (start) begin
            st_r <= st_busy;
          end
        end
        st_busy: begin
          if (ack) begin
            st_r <= st_idle;
          end
        end
        default: begin
          st_r <= st_idle;
        end
      endcase
    end
  end

  // completion beats a simultaneous clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if (fin) begin
      done <= 1'b1;
    end else if (clr || start) begin
      done <= 1'b0;
    end
  end

endmodule : seeio_xfer

/* File: tb.sv */
// self-checking bench for the eeprom / expander register bank
`timescale 1ns/1ps
`include "seeio_regs.svh"
module tb;
  import seeio_pkg::*;
  localparam logic [63:0] DIR  = {4{16'h00ff}};
  localparam logic [63:0] CORE = 64'h1234_5678_9abc_def0;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, q;
  logic [3:0]     pstrb;
  logic           eep_valid, eep_ack, ioe_valid, ioe_ack;
  seeio_eep_req_t eep_req;
  seeio_ioe_req_t ioe_req;
  logic [7:0]     eep_rdata;
  logic [15:0]    ioe_rdata, pins;
  logic [63:0]    ioe_dir, ioe_core, ioe_drive;
  logic [3:0]     cd [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
  int             n_errors, n_checks;
  int             cyc = 0;
  seeio_access u_seeio_access (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eep_valid(eep_valid), .eep_req(eep_req),
    .eep_ack(eep_ack), .eep_rdata(eep_rdata), .ioe_valid(ioe_valid), .ioe_req(ioe_req),
    .ioe_ack(ioe_ack), .ioe_rdata(ioe_rdata), .ioe_dir(ioe_dir), .ioe_core(ioe_core),
    .ioe_drive(ioe_drive), .irq(irq));
  seeio_far u_seeio_far (.pclk(pclk), .presetn(presetn), .eep_valid(eep_valid),
    .eep_req(eep_req), .eep_ack(eep_ack), .eep_rdata(eep_rdata), .ioe_valid(ioe_valid),
    .ioe_req(ioe_req), .ioe_ack(ioe_ack), .ioe_rdata(ioe_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask : rd
  // software reads the register until its completion bit is up, giving up after 40 more reads
  task poll(input logic [11:0] a, input int b);
    int i;
    i = 0;
    rd(a);
    while (q[b] !== 1'b1 && i < 40) begin
      rd(a);
      i++;
    end
  endtask : poll
  task test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset();
    rd(`SEEIO_EEP_OFS);
    chk("eeprom reset", q, 32'h0000_0000);
    rd(`SEEIO_IOE_OFS);
    chk("pin reset", q, {16'h0000, CORE[15:0] & ~DIR[15:0]});
    apb(1'b1, 12'h3fc, 32'hffff_ffff, 4'hf);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    rd(12'h3fc);
    chk("unmapped data", q, 32'h0000_0000);
  endtask : t_reset
  task t_eep_write();
    apb(1'b1, `SEEIO_IEN_OFS, 32'h0000_0003, 4'hf);
    apb(1'b1, `SEEIO_EEP_OFS, 32'h005a_8012, 4'hf);
    rd(`SEEIO_EEP_OFS);
    chk("busy in flight", q, 32'h015a_8012);
    poll(`SEEIO_EEP_OFS, 25);
    chk("write done", q, 32'h025a_8012);
    chk("stored byte", {24'h0, u_seeio_far.mem[8'h12]}, 32'h0000_005a);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    rd(`SEEIO_IST_OFS);
    chk("status eeprom", q, 32'h0000_0001);
    apb(1'b1, `SEEIO_ICL_OFS, 32'h0000_0001, 4'hf);
    rd(`SEEIO_IST_OFS);
    chk("status cleared", q, 32'h0000_0000);
    chk("irq dropped", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `SEEIO_EEP_OFS, 32'h0200_0000, 4'h8);
    rd(`SEEIO_EEP_OFS);
    chk("done w1c", q, 32'h005a_8012);
  endtask : t_eep_write
  task t_eep_read();
    apb(1'b1, `SEEIO_IEN_OFS, 32'h0000_0000, 4'hf);
    apb(1'b1, `SEEIO_EEP_OFS, 32'h04ff_8012, 4'hf);
    poll(`SEEIO_EEP_OFS, 25);
    chk("read result", q, 32'h065a_8012);
    chk("byte untouched", {24'h0, u_seeio_far.mem[8'h12]}, 32'h0000_005a);
    rd(`SEEIO_IST_OFS);
    chk("status masked", q, 32'h0000_0001);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `SEEIO_ICL_OFS, 32'h0000_0001, 4'hf);
  endtask : t_eep_read
  task t_ioe();
    apb(1'b1, `SEEIO_IEN_OFS, 32'h0000_0002, 4'hf);
    apb(1'b1, `SEEIO_IOE_OFS, {2'b00, 4'h1, 10'h000, 16'hffff}, 4'hf);
    rd(`SEEIO_IOE_OFS);
    chk("pin write dropped", q, {2'b00, 4'h1, 10'h000, CORE[31:16] & ~DIR[31:16]});
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SEEIO_IOE_OFS, {2'b00, cd[i], 1'b0, 1'b1, 24'h000000}, 4'h8);
      poll(`SEEIO_IOE_OFS, 31);
      pins = ((16'ha5c0 | 16'(i)) & DIR[16*i +: 16]) | (CORE[16*i +: 16] & ~DIR[16*i +: 16]);
      chk("refresh pins", q, {2'b10, cd[i], 2'b00, 8'h00, pins});
      chk("refresh kind", {31'h0, ioe_req.refresh}, 32'h0000_0001);
      apb(1'b1, `SEEIO_IOE_OFS, {2'b10, cd[i], 26'h0000000}, 4'h8);
      rd(`SEEIO_IOE_OFS);
      chk("ioe done w1c", {31'h0, q[31]}, 32'h0000_0000);
    end
    chk("irq expander", {31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `SEEIO_ICL_OFS, 32'h0000_0002, 4'hf);
    // input bits must keep the read-back value even under test mode
    // test mode must already be on when the pin write arrives, so set it first
    apb(1'b1, `SEEIO_IOE_OFS, {2'b00, 4'h1, 1'b1, 25'h0000000}, 4'h8);
    apb(1'b1, `SEEIO_IOE_OFS, {2'b00, 4'h1, 1'b1, 1'b0, 8'h00, 16'h0f0f}, 4'hf);
    poll(`SEEIO_IOE_OFS, 31);
    chk("test pins", q, {2'b10, 4'h1, 1'b1, 1'b0, 8'h00, 16'h0fc1});
    chk("test drive", {16'h0, ioe_drive[31:16]}, 32'h0000_0f00);
    chk("core ignored", {16'h0, ioe_drive[15:0]}, 32'h0000_0000);
    chk("update kind", {31'h0, ioe_req.refresh}, 32'h0000_0000);
    apb(1'b1, `SEEIO_IOE_OFS, {2'b10, 4'h1, 26'h0000000}, 4'h8);
    rd(`SEEIO_IOE_OFS);
    chk("core restored", {16'h0, ioe_drive[31:16]}, {16'h0, CORE[31:16] & ~DIR[31:16]});
    apb(1'b1, `SEEIO_IOE_OFS, {2'b00, 4'h3, 2'b01, 24'h000000}, 4'h8);
    rd(`SEEIO_IOE_OFS);
    chk("reserved select", q, {2'b00, 4'h3, 26'h0000000});
    chk("reserved idle", {31'h0, ioe_valid}, 32'h0000_0000);
  endtask : t_ioe
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_checks = 0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    pstrb    = 4'h0;
    ioe_dir  = DIR;
    ioe_core = CORE;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_eep_write();
    t_eep_read();
    t_ioe();
    test_done();
  end
endmodule : tb
